// >>> pkg/lim_pkg.sv
package lim_pkg;

    // Register map (word offsets chosen for this block)
    localparam logic [3:0] ADDR_MODE_CONTROL   = 4'h0;
    localparam logic [3:0] ADDR_MASTER_CONTROL = 4'h1;
    localparam logic [3:0] ADDR_PATH_STATUS    = 4'h2;

    // Port mode control field positions
    localparam int BIT_TX_POWER_DOWN   = 7;
    localparam int BIT_RX_POWER_DOWN   = 6;
    localparam int BIT_PAR_CLK_DIR     = 5;
    localparam int BIT_SERIAL_PATH_HI  = 4;
    localparam int BIT_SERIAL_PATH_LO  = 3;

    // Master control field position
    localparam int BIT_IFACE_WIDTH_SEL = 5;

    // Reset values of software-only bits
    localparam logic       RST_TX_POWER_DOWN = 1'b0;
    localparam logic       RST_RX_POWER_DOWN = 1'b0;
    localparam logic       RST_IFACE_WIDTH   = 1'b0;

    // Clock mode strap encodings and resulting serial path defaults
    localparam logic [1:0] STRAP_LOW   = 2'h0;
    localparam logic [1:0] STRAP_HIGH  = 2'h1;
    localparam logic [1:0] STRAP_FLOAT = 2'h2;
    localparam logic [1:0] PATH_RST_LOW   = 2'h0;
    localparam logic [1:0] PATH_RST_HIGH  = 2'h1;
    localparam logic [1:0] PATH_RST_FLOAT = 2'h3;

    // Serial transmit path select encodings
    typedef enum logic [1:0] {
        LIM_PATH_FIFO_ONLY = 2'h0,
        LIM_PATH_PLESIO    = 2'h1,
        LIM_PATH_CDR_FIFO  = 2'h2,
        LIM_PATH_LOOP      = 2'h3
    } lim_path_e;

    // Synchroniser depth in cycles; the strap capture comes on the edge after
    localparam int STRAP_SETTLE_CYCLES = 2;

endpackage

// >>> design/lim_sync.sv
`timescale 1ns/1ps

// Two-stage synchroniser for pin levels
module lim_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic             i_ce,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    // A zero-width synchroniser has nothing to carry
    if (WIDTH < 1) begin : g_bad_width
        $error("lim_sync width must be positive");
    end

    // First stage feeds only the second
    always_comb begin
        meta_next = i_ce ? i_async : meta_reg;
        sync_next = i_ce ? meta_reg : sync_reg;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign o_sync = sync_reg;
endmodule // lim_sync

// >>> design/lim_mode_control.sv
`timescale 1ns/1ps

// Functional notes
// - Power-down bits stop tx/rx, tri-state line output
// - Serial interface forces clock direction field one
// - Parallel interface: field picks tx clock source
// - Field zero: framer clock captures transmit data
// - Field one: device drives transmit clock out
// - Clock direction reset value from strap pin
// - Serial interface: path field configures transmit input
// - Path field reset value from clock strap
// - Path 00: FIFO only, recovery bypassed
// - Path 10: recovery then FIFO
// - Path 01: recovery only, FIFO bypassed
// - Path 11: loop timing from receive clock
// - Width select: 0 serial, 1 four-bit parallel
// - Strap float 11, low 00, high 01
module lim_mode_control (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_ce,
    // Avalon-MM slave
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // Strap pins
    input  wire logic        i_par_clk_dir_strap,
    input  wire logic [1:0]  i_clock_mode_strap,
    // Transmit datapath controls
    input  wire logic        i_parallel_tx_clock_in,
    output logic             o_tx_power_down,
    output logic             o_tx_line_oe,
    output logic             o_rx_power_down,
    output logic             o_parallel_mode,
    output logic             o_parallel_tx_clock_out,
    output logic             o_parallel_tx_clock_out_oe,
    output logic             o_tx_capture_ext_clk,
    output logic             o_cdr_enable,
    output logic             o_fifo_enable,
    output logic             o_loop_timing
);
    logic [1:0] strap_path;
    logic [1:0] strap_path_sync;
    logic       strap_dir_sync;
    logic       ptclk_sync;

    logic       tx_pd_reg,   tx_pd_next;
    logic       rx_pd_reg,   rx_pd_next;
    logic       dir_reg,     dir_next;
    logic [1:0] path_reg,    path_next;
    logic       width_reg,   width_next;
    logic [1:0] settle_reg,  settle_next;
    logic       ack_reg,     ack_next;
    logic [31:0] rdata_reg,  rdata_next;
    logic       clkout_reg,  clkout_next;
    logic       cap_reg,     cap_next;
    logic       dir_eff;
    logic [7:0] mode_view;

    // Settle count at which the straps are in and the bus opens
    localparam logic [1:0] SETTLE_DONE = 2'(lim_pkg::STRAP_SETTLE_CYCLES + 1);

    // Strap mapping decoded once, used by reset capture
    function automatic logic [1:0] strap_to_path(input logic [1:0] s);
        case (s)
            lim_pkg::STRAP_LOW:   strap_to_path = lim_pkg::PATH_RST_LOW;
            lim_pkg::STRAP_HIGH:  strap_to_path = lim_pkg::PATH_RST_HIGH;
            lim_pkg::STRAP_FLOAT: strap_to_path = lim_pkg::PATH_RST_FLOAT;
            default:              strap_to_path = lim_pkg::PATH_RST_FLOAT;
        endcase
    endfunction

    // Straps and framer clock are asynchronous pins
    lim_sync #(
        .WIDTH(4)
    ) u_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_ce    (i_ce),
        .i_async ({ i_parallel_tx_clock_in, i_par_clk_dir_strap, i_clock_mode_strap }),
        .o_sync  ({ ptclk_sync, strap_dir_sync, strap_path })
    );
    assign strap_path_sync = strap_path;

    // Clock direction reads as one while serial is selected
    assign dir_eff = width_reg ? dir_reg : 1'b1;

    assign mode_view = { tx_pd_reg, rx_pd_reg, dir_eff, path_reg, 3'h0 };

    // Register next state: strap capture, bus writes, read data
    always_comb begin
        tx_pd_next  = tx_pd_reg;
        rx_pd_next  = rx_pd_reg;
        dir_next    = dir_reg;
        path_next   = path_reg;
        width_next  = width_reg;
        settle_next = settle_reg;
        ack_next    = 1'b0;
        rdata_next  = rdata_reg;
        // Synchroniser output holds the strap only once both flops have
        // filled, so capture comes one edge after the synchroniser depth
        if (settle_reg != SETTLE_DONE) begin
            settle_next = settle_reg + 2'h1;
            if (settle_reg == 2'(lim_pkg::STRAP_SETTLE_CYCLES)) begin
                dir_next  = strap_dir_sync;
                path_next = strap_to_path(strap_path_sync);
            end
        end else if ((i_avs_read || i_avs_write) && !ack_reg) begin
            ack_next = 1'b1;
            if (i_avs_write) begin
                case (i_avs_address)
                    lim_pkg::ADDR_MODE_CONTROL: begin
                        tx_pd_next = i_avs_writedata[lim_pkg::BIT_TX_POWER_DOWN];
                        rx_pd_next = i_avs_writedata[lim_pkg::BIT_RX_POWER_DOWN];
                        dir_next   = i_avs_writedata[lim_pkg::BIT_PAR_CLK_DIR];
                        path_next  = { i_avs_writedata[lim_pkg::BIT_SERIAL_PATH_HI],
                                       i_avs_writedata[lim_pkg::BIT_SERIAL_PATH_LO] };
                    end
                    lim_pkg::ADDR_MASTER_CONTROL: begin
                        width_next = i_avs_writedata[lim_pkg::BIT_IFACE_WIDTH_SEL];
                    end
                    default: begin
                    end
                endcase
            end else begin
                case (i_avs_address)
                    lim_pkg::ADDR_MODE_CONTROL:   rdata_next = { 24'h0, mode_view };
                    lim_pkg::ADDR_MASTER_CONTROL:
                        rdata_next = 32'(width_reg) << lim_pkg::BIT_IFACE_WIDTH_SEL;
                    lim_pkg::ADDR_PATH_STATUS:
                        rdata_next = { 28'h0, o_loop_timing, o_fifo_enable,
                                       o_cdr_enable, o_tx_capture_ext_clk };
                    default:                      rdata_next = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            tx_pd_reg  <= lim_pkg::RST_TX_POWER_DOWN;
            rx_pd_reg  <= lim_pkg::RST_RX_POWER_DOWN;
            dir_reg    <= 1'b1;
            path_reg   <= lim_pkg::PATH_RST_FLOAT;
            width_reg  <= lim_pkg::RST_IFACE_WIDTH;
            settle_reg <= 2'h0;
            ack_reg    <= 1'b0;
            rdata_reg  <= 32'h0;
        end else if (i_ce) begin
            tx_pd_reg  <= tx_pd_next;
            rx_pd_reg  <= rx_pd_next;
            dir_reg    <= dir_next;
            path_reg   <= path_next;
            width_reg  <= width_next;
            settle_reg <= settle_next;
            ack_reg    <= ack_next;
            rdata_reg  <= rdata_next;
        end
    end

    // Waitrequest drops for one cycle once the access is done
    assign o_avs_waitrequest = !ack_reg;
    assign o_avs_readdata    = rdata_reg;

    // Transmit clocking: master divides i_clk, slave samples framer clock
    always_comb begin
        clkout_next = clkout_reg;
        cap_next    = 1'b0;
        if (width_reg && dir_eff && !tx_pd_reg) begin
            clkout_next = !clkout_reg;
        end else begin
            clkout_next = 1'b0;
        end
        if (width_reg && !dir_eff) begin
            cap_next = ptclk_sync;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            clkout_reg <= 1'b0;
            cap_reg    <= 1'b0;
        end else if (i_ce) begin
            clkout_reg <= clkout_next;
            cap_reg    <= cap_next;
        end
    end

    assign o_parallel_tx_clock_out    = clkout_reg;
    assign o_parallel_tx_clock_out_oe = width_reg && dir_eff && !tx_pd_reg;
    assign o_tx_capture_ext_clk       = width_reg && !dir_eff;
    assign o_parallel_mode            = width_reg;

    // Power-down controls and line driver enable
    assign o_tx_power_down = tx_pd_reg;
    assign o_rx_power_down = rx_pd_reg;
    assign o_tx_line_oe    = !tx_pd_reg;

    // Serial path decode; parallel mode always uses FIFO with no recovery
    always_comb begin
        o_cdr_enable  = 1'b0;
        o_fifo_enable = 1'b1;
        o_loop_timing = 1'b0;
        if (!width_reg) begin
            case (lim_pkg::lim_path_e'(path_reg))
                lim_pkg::LIM_PATH_FIFO_ONLY: begin
                    o_cdr_enable  = 1'b0;
                    o_fifo_enable = 1'b1;
                end
                lim_pkg::LIM_PATH_CDR_FIFO: begin
                    o_cdr_enable  = 1'b1;
                    o_fifo_enable = 1'b1;
                end
                lim_pkg::LIM_PATH_PLESIO: begin
                    o_cdr_enable  = 1'b1;
                    o_fifo_enable = 1'b0;
                end
                lim_pkg::LIM_PATH_LOOP: begin
                    o_loop_timing = 1'b1;
                end
                default: begin
                    o_fifo_enable = 1'b1;
                end
            endcase
        end
    end

    // Checks
    a_line_oe_pd: assert property (@(posedge i_clk) disable iff (i_reset)
        o_tx_line_oe == !o_tx_power_down)
        else $error("line enable disagrees with power down");
    a_serial_dir_one: assert property (@(posedge i_clk) disable iff (i_reset)
        !o_parallel_mode |-> mode_view[lim_pkg::BIT_PAR_CLK_DIR])
        else $error("clock direction not one in serial");
    a_slave_capture: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_parallel_mode && !dir_reg) |-> (o_tx_capture_ext_clk && !o_parallel_tx_clock_out_oe))
        else $error("slave timing wrong");
    a_master_drive: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_parallel_mode && dir_reg && !tx_pd_reg && i_ce && $stable(dir_reg)
         && $past(o_parallel_tx_clock_out_oe)) |=> (o_parallel_tx_clock_out != $past(clkout_reg)))
        else $error("master clock not toggling");
    a_path_fifo: assert property (@(posedge i_clk) disable iff (i_reset)
        (!width_reg && path_reg == 2'h0) |-> (o_fifo_enable && !o_cdr_enable))
        else $error("fifo only path wrong");
    a_path_cdr: assert property (@(posedge i_clk) disable iff (i_reset)
        (!width_reg && path_reg == 2'h2) |-> (o_fifo_enable && o_cdr_enable))
        else $error("cdr fifo path wrong");
    a_path_plesio: assert property (@(posedge i_clk) disable iff (i_reset)
        (!width_reg && path_reg == 2'h1) |-> (!o_fifo_enable && o_cdr_enable))
        else $error("plesiochronous path wrong");
    a_path_loop: assert property (@(posedge i_clk) disable iff (i_reset)
        (!width_reg && path_reg == 2'h3) |-> o_loop_timing)
        else $error("loop timing missing");
    a_par_ignore: assert property (@(posedge i_clk) disable iff (i_reset)
        width_reg |-> (!o_loop_timing && !o_cdr_enable))
        else $error("serial path active in parallel");
    a_par_fifo_on: assert property (@(posedge i_clk) disable iff (i_reset)
        o_parallel_mode |-> o_fifo_enable)
        else $error("fifo off in parallel");

    // Bus handshake and strap capture; an early capture would load reset zeros
    a_ack_single: assert property (@(posedge i_clk) disable iff (i_reset)
        (ack_reg && i_ce) |=> !ack_reg)
        else $error("waitrequest low for more than one cycle");
    a_ack_has_req: assert property (@(posedge i_clk) disable iff (i_reset)
        (ack_reg && $past(i_ce)) |-> $past(i_avs_read || i_avs_write))
        else $error("acknowledge without request");
    a_wait_settle: assert property (@(posedge i_clk) disable iff (i_reset)
        (settle_reg != SETTLE_DONE) |-> o_avs_waitrequest)
        else $error("bus answered before straps settled");
    a_strap_load: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_ce && settle_reg == 2'(lim_pkg::STRAP_SETTLE_CYCLES))
        |=> (dir_reg == $past(strap_dir_sync) && path_reg == strap_to_path($past(strap_path_sync))))
        else $error("strap levels not captured");
    a_mode_write: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_ce && settle_reg == SETTLE_DONE && !ack_reg && i_avs_write
         && i_avs_address == lim_pkg::ADDR_MODE_CONTROL)
        |=> (tx_pd_reg == $past(i_avs_writedata[lim_pkg::BIT_TX_POWER_DOWN])
             && rx_pd_reg == $past(i_avs_writedata[lim_pkg::BIT_RX_POWER_DOWN])
             && path_reg == $past(i_avs_writedata[lim_pkg::BIT_SERIAL_PATH_HI
                                                  :lim_pkg::BIT_SERIAL_PATH_LO])))
        else $error("mode control write lost");
    a_width_write: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_ce && settle_reg == SETTLE_DONE && !ack_reg && i_avs_write
         && i_avs_address == lim_pkg::ADDR_MASTER_CONTROL)
        |=> (o_parallel_mode == $past(i_avs_writedata[lim_pkg::BIT_IFACE_WIDTH_SEL])))
        else $error("interface width write lost");
    a_rd_unmapped: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_ce && settle_reg == SETTLE_DONE && !ack_reg && i_avs_read && !i_avs_write
         && i_avs_address > lim_pkg::ADDR_PATH_STATUS) |=> (o_avs_readdata == 32'h0))
        else $error("unmapped read not zero");

    // Clock enable, idle clock level and slave capture
    a_ce_freeze: assert property (@(posedge i_clk) disable iff (i_reset)
        !i_ce |=> ($stable(tx_pd_reg) && $stable(path_reg) && $stable(width_reg)
                   && $stable(clkout_reg) && $stable(settle_reg)))
        else $error("state moved with clock enable low");
    a_clk_idle: assert property (@(posedge i_clk) disable iff (i_reset)
        (!o_parallel_tx_clock_out_oe && i_ce) |=> !o_parallel_tx_clock_out)
        else $error("parallel clock not parked low");
    a_pd_no_clk: assert property (@(posedge i_clk) disable iff (i_reset)
        o_tx_power_down |-> !o_parallel_tx_clock_out_oe)
        else $error("clock driven while powered down");
    a_serial_quiet: assert property (@(posedge i_clk) disable iff (i_reset)
        !o_parallel_mode |-> (!o_parallel_tx_clock_out_oe && !o_tx_capture_ext_clk))
        else $error("parallel clocking active in serial");
    a_cap_follow: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_tx_capture_ext_clk && i_ce) |=> (cap_reg == $past(ptclk_sync)))
        else $error("framer clock not captured");
endmodule // lim_mode_control

// >>> test/lim_framer_model.sv
`timescale 1ns/1ps

// Framer on the system side: supplies the slave clock, watches the master clock
module lim_framer_model (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_dev_clk,
    input  wire logic i_dev_clk_oe,
    output logic      o_tx_clk,
    output int        o_toggles
);
    logic last_reg;

    // Clock toward the device toggles every cycle; when the device ignores it,
    // the changing pattern keeps a stale level from looking valid
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_tx_clk <= 1'b0;
        end else begin
            o_tx_clk <= ~o_tx_clk;
        end
    end

    // Count edges of the device clock only while it is really driven
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_toggles <= 0;
            last_reg  <= 1'b0;
        end else begin
            last_reg <= i_dev_clk;
            if (i_dev_clk_oe && (i_dev_clk !== last_reg)) begin
                o_toggles <= o_toggles + 1;
            end
        end
    end
endmodule // lim_framer_model

// >>> test/testbench.sv
`timescale 1ns/1ps

module testbench;
    logic        i_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic [3:0]  adr = 4'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic        wreq, txpd, loe, rxpd, parm, pclk, pclk_oe, capx, cdr, fifo, loopt, fclk;
    logic        dstrap = 1'b0;
    logic        ce = 1'b1;
    logic [1:0]  cstrap = 2'h0;
    logic [31:0] q, wv;
    logic        par;
    int          toggles, t0;
    int          seed = 41;
    int          err_total = 0;
    int          checks = 0;

    always #25 i_clk = ~i_clk;

    lim_mode_control lim_mode_control_i (.i_clk(i_clk), .i_reset(i_reset), .i_ce(ce),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_par_clk_dir_strap(dstrap),
        .i_clock_mode_strap(cstrap), .i_parallel_tx_clock_in(fclk), .o_tx_power_down(txpd),
        .o_tx_line_oe(loe), .o_rx_power_down(rxpd), .o_parallel_mode(parm),
        .o_parallel_tx_clock_out(pclk), .o_parallel_tx_clock_out_oe(pclk_oe),
        .o_tx_capture_ext_clk(capx), .o_cdr_enable(cdr), .o_fifo_enable(fifo),
        .o_loop_timing(loopt));

    lim_framer_model lim_framer_model_i (.i_clk(i_clk), .i_reset(i_reset), .i_dev_clk(pclk),
        .i_dev_clk_oe(pclk_oe), .o_tx_clk(fclk), .o_toggles(toggles));

    // Verdict and end of run, shared with every timeout
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One Avalon access; request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        adr <= a;
        wr  <= w;
        rd  <= !w;
        wd  <= d;
        @(posedge i_clk);
        while (wreq !== 1'b0) begin
            n++;
            if (n > 200) begin
                err_total++;
                stop_test();
            end
            @(posedge i_clk);
        end
        r = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic do_reset(input logic [1:0] cs, input logic ds);
        i_reset <= 1'b1;
        cstrap  <= cs;
        dstrap  <= ds;
        repeat (10) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
    endtask

    // Strap level to serial path default: low 00, high 01, float 11
    function automatic logic [1:0] path_of(input logic [1:0] cs);
        return (cs == 2'h0) ? 2'h0 : (cs == 2'h1) ? 2'h1 : 2'h3;
    endfunction

    // Expected path status {loop, cdr, fifo, capture}
    function automatic logic [3:0] est(input logic p, input logic [31:0] v);
        if (p) return {3'b001, !v[5]};
        case (v[4:3])
            2'h0:    return 4'b0010;
            2'h2:    return 4'b0110;
            2'h1:    return 4'b0100;
            default: return 4'b1000;
        endcase
    endfunction

    // Readback of all registers, then the control ports once settled
    task automatic check_all(input logic p, input logic [31:0] v);
        logic [3:0] m;
        m = (!p && v[4:3] == 2'h3) ? 4'b1001 : 4'b1111; // Loop mode leaves CDR/FIFO open
        bus(1'b0, 4'h1, 32'h0, q);
        chk(q, {26'h0, p, 5'h0});
        bus(1'b0, 4'h0, 32'h0, q);
        chk(q, {24'h0, v[7:6], p ? v[5] : 1'b1, v[4:3], 3'h0});
        bus(1'b0, 4'h2, 32'h0, q);
        chk({q[3], q[1], q[2], q[0]} & m, est(p, v) & m);
        @(negedge i_clk);
        chk({loopt, cdr, fifo, capx} & m, est(p, v) & m);
        chk({txpd, loe, rxpd, parm}, {v[7], !v[7], v[6], p});
        chk(pclk_oe, p & v[5] & !v[7]);
        if (!(p && v[5])) chk(pclk, 1'b0);
        @(posedge i_clk);
    endtask

    initial begin
        // Strap defaults: path read in serial, clock direction seen through the parallel interface
        for (int s = 0; s < 4; s++) begin
            do_reset(s[1:0], s[0]);
            bus(1'b0, 4'h0, 32'h0, q);
            chk(q, {24'h0, 2'b00, 1'b1, path_of(s[1:0]), 3'h0});
            bus(1'b1, 4'h1, 32'h20, q);
            bus(1'b0, 4'h0, 32'h0, q);
            chk(q[5], s[0]);
            bus(1'b1, 4'h1, 32'h0, q);
        end
        // First eight cover every path in both widths, the rest random
        for (int k = 0; k < 48; k++) begin
            wv  = $random(seed);
            par = wv[31];
            if (k < 8) begin
                par      = k[2];
                wv[4:3]  = k[1:0];
                wv[7:5]  = {k[0], k[1], k[0]};
            end
            bus(1'b1, 4'h1, {$random(seed)} & 32'hFFFF_FFDF | {26'h0, par, 5'h0}, q);
            bus(1'b1, 4'h0, wv, q);
            check_all(par, wv);
        end
        // Master timing: device clock runs toward the framer
        bus(1'b1, 4'h1, 32'h20, q);
        bus(1'b1, 4'h0, 32'h20, q);
        t0 = toggles;
        repeat (6) @(posedge i_clk);
        chk(toggles - t0 >= 5, 1'b1);
        // Clock enable low freezes the master clock toward the framer
        ce <= 1'b0;
        repeat (2) @(posedge i_clk);
        t0 = toggles;
        repeat (4) @(posedge i_clk);
        chk(toggles - t0, 0);
        ce <= 1'b1;
        // Unmapped write ignored, unmapped read gives zero
        bus(1'b1, 4'h7, 32'hFF, q);
        bus(1'b1, 4'hF, 32'hFF, q);
        check_all(1'b1, 32'h20);
        bus(1'b0, 4'h9, 32'h0, q);
        chk(q, 32'h0);
        // Reset in mid-run restores defaults
        do_reset(2'h2, 1'b0);
        check_all(1'b0, 32'h18);
        stop_test();
    end
endmodule // testbench
